// ---- rtl/event_timestamp_counter.sv ----
`timescale 1ns/1ps
module event_timestamp_counter (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // reference tick, local and satellite second marks
    input wire logic ref_tick_i,
    input wire logic local_pps_i,
    input wire logic sat_pps_i,
    // time of day preset
    input wire logic set_time_i,
    input wire timestamp_pkg::time_bcd_t set_value_i,
    // differential timestamp to event modules
    output timestamp_pkg::timestamp_t ts_p_o,
    output timestamp_pkg::timestamp_t ts_n_o,
    // offset report line
    output logic offset_tx_o,
    output logic offset_busy_o
);

    typedef struct packed {
        logic [23:0] sub;
        timestamp_pkg::timestamp_t ts;
        timestamp_pkg::meas_state_t meas;
        logic [22:0] gap;
        logic [23:0] result;
        timestamp_pkg::tx_state_t tx;
        logic [10:0] baud;
        logic [2:0] bitn;
        logic [1:0] byten;
        logic [7:0] shreg;
        logic line;
    } core_t;

    core_t state;
    core_t next_state;
    timestamp_pkg::time_bcd_t tod;
    logic [3:0] su;
    logic [3:0] st;
    logic [3:0] mu;
    logic [3:0] mt;
    logic [3:0] hu;
    logic [3:0] ht;
    logic c_su;
    logic c_st;
    logic c_mu;
    logic c_mt;
    logic c_hu;
    logic c_ht;
    logic [3:0] hu_last;
    logic report;
    logic [23:0] report_value;
    logic baud_end;

    // hour units stop at 3 once the tens read 2
    assign hu_last = (ht == timestamp_pkg::HOUR_TENS_LAST) ? timestamp_pkg::HOUR_UNITS_AT2_LAST
        : timestamp_pkg::UNITS_LAST;

    // R8 second, minute, hour carry chain
    bcd_digit u_sec_units (.clk_i(clk_i), .reset_i(reset_i), .load_i(set_time_i),
        .load_value_i(set_value_i.sec_units), .inc_i(local_pps_i), .last_i(timestamp_pkg::UNITS_LAST),
        .digit_o(su), .carry_o(c_su));
    bcd_digit u_sec_tens (.clk_i(clk_i), .reset_i(reset_i), .load_i(set_time_i),
        .load_value_i({1'b0, set_value_i.sec_tens}), .inc_i(c_su), .last_i(timestamp_pkg::TENS6_LAST),
        .digit_o(st), .carry_o(c_st));
    bcd_digit u_min_units (.clk_i(clk_i), .reset_i(reset_i), .load_i(set_time_i),
        .load_value_i(set_value_i.min_units), .inc_i(c_st), .last_i(timestamp_pkg::UNITS_LAST),
        .digit_o(mu), .carry_o(c_mu));
    bcd_digit u_min_tens (.clk_i(clk_i), .reset_i(reset_i), .load_i(set_time_i),
        .load_value_i({1'b0, set_value_i.min_tens}), .inc_i(c_mu), .last_i(timestamp_pkg::TENS6_LAST),
        .digit_o(mt), .carry_o(c_mt));
    bcd_digit u_hour_units (.clk_i(clk_i), .reset_i(reset_i), .load_i(set_time_i),
        .load_value_i(set_value_i.hour_units), .inc_i(c_mt), .last_i(hu_last),
        .digit_o(hu), .carry_o(c_hu));
    bcd_digit u_hour_tens (.clk_i(clk_i), .reset_i(reset_i), .load_i(set_time_i),
        .load_value_i({2'b00, set_value_i.hour_tens}), .inc_i(c_hu), .last_i(timestamp_pkg::HOUR_TENS_LAST),
        .digit_o(ht), .carry_o(c_ht));

    // R4 hhmmss kept as bcd digits
    // R5 pack digits into the 20-bit field, narrow digits cut to size
    assign tod = {ht[1:0], hu, mt[2:0], mu, st[2:0], su};

    // sign and magnitude of the offset: sign set when the satellite came first
    always_comb
    begin
        report = 1'b0;
        report_value = 24'h000000;
        case (state.meas)
            timestamp_pkg::MEAS_IDLE:
            begin
                if (local_pps_i && sat_pps_i)
                    report = 1'b1;
            end
            timestamp_pkg::MEAS_LOCAL_FIRST:
            begin
                report = sat_pps_i && !local_pps_i;
                report_value = {1'b0, state.gap};
            end
            timestamp_pkg::MEAS_SAT_FIRST:
            begin
                report = local_pps_i && !sat_pps_i;
                report_value = {1'b1, state.gap};
            end
            default:
                report = 1'b0;
        endcase
    end

    assign baud_end = (state.baud == timestamp_pkg::BIT_LAST);

    // next state of counter, measurement and serial sender
    always_comb
    begin
        next_state = state;
        // R1 one count per reference tick
        if (ref_tick_i)
            next_state.sub = 24'(state.sub + 24'h000001);
        // R2 second mark clears the count, wins over a tick
        if (local_pps_i)
            next_state.sub = timestamp_pkg::SUB_RESET;
        // R3 binary count beside the time of day, one cycle behind
        next_state.ts = {tod, state.sub};

        // R7 count 100 ns cycles between the two second marks
        if (state.gap != timestamp_pkg::GAP_MAX)
            next_state.gap = 23'(state.gap + 23'h000001);
        case (state.meas)
            timestamp_pkg::MEAS_IDLE:
            begin
                next_state.gap = 23'h000000;
                if (local_pps_i && !sat_pps_i)
                    next_state.meas = timestamp_pkg::MEAS_LOCAL_FIRST;
                else if (sat_pps_i && !local_pps_i)
                    next_state.meas = timestamp_pkg::MEAS_SAT_FIRST;
            end
            timestamp_pkg::MEAS_LOCAL_FIRST:
            begin
                // a repeated local mark restarts, the missing one is not reported
                if (local_pps_i)
                    next_state.gap = 23'h000000;
                else if (sat_pps_i)
                    next_state.meas = timestamp_pkg::MEAS_IDLE;
            end
            timestamp_pkg::MEAS_SAT_FIRST:
            begin
                if (sat_pps_i)
                    next_state.gap = 23'h000000;
                else if (local_pps_i)
                    next_state.meas = timestamp_pkg::MEAS_IDLE;
            end
            default:
                next_state.meas = timestamp_pkg::MEAS_IDLE;
        endcase

        // R7 three bytes, 8N1, lsb first; a result during a send is dropped
        next_state.baud = baud_end ? 11'h000 : 11'(state.baud + 11'h001);
        case (state.tx)
            timestamp_pkg::TX_IDLE:
            begin
                next_state.baud = 11'h000;
                if (report)
                begin
                    next_state.result = report_value;
                    next_state.shreg = report_value[23:16];
                    next_state.byten = 2'h0;
                    next_state.line = 1'b0;
                    next_state.tx = timestamp_pkg::TX_START;
                end
            end
            timestamp_pkg::TX_START:
            begin
                if (baud_end)
                begin
                    next_state.line = state.shreg[0];
                    next_state.bitn = 3'h0;
                    next_state.tx = timestamp_pkg::TX_DATA;
                end
            end
            timestamp_pkg::TX_DATA:
            begin
                if (baud_end)
                begin
                    if (state.bitn == timestamp_pkg::DATA_LAST)
                    begin
                        next_state.line = timestamp_pkg::LINE_IDLE;
                        next_state.tx = timestamp_pkg::TX_STOP;
                    end
                    else
                    begin
                        next_state.shreg = {1'b0, state.shreg[7:1]};
                        next_state.line = state.shreg[1];
                        next_state.bitn = 3'(state.bitn + 3'h1);
                    end
                end
            end
            timestamp_pkg::TX_STOP:
            begin
                if (baud_end)
                begin
                    if (state.byten == timestamp_pkg::BYTES_LAST)
                        next_state.tx = timestamp_pkg::TX_IDLE;
                    else
                    begin
                        next_state.byten = 2'(state.byten + 2'h1);
                        next_state.shreg = (state.byten == 2'h0) ? state.result[15:8] : state.result[7:0];
                        next_state.line = 1'b0;
                        next_state.tx = timestamp_pkg::TX_START;
                    end
                end
            end
            default:
                next_state.tx = timestamp_pkg::TX_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state <= '0;
            state.meas <= timestamp_pkg::MEAS_IDLE;
            state.tx <= timestamp_pkg::TX_IDLE;
            state.line <= timestamp_pkg::LINE_IDLE;
        end
        else
            state <= next_state;
    end

    // R6 true and complement copies of the registered word
    assign ts_p_o = state.ts;
    assign ts_n_o = ~state.ts;
    assign offset_tx_o = state.line;
    assign offset_busy_o = (state.tx != timestamp_pkg::TX_IDLE);

    // R1 tick advances count; the reset edge itself is excluded, its update is the reset
    a_tick_count: assert property (@(posedge clk_i) disable iff (reset_i) // R1
        (!reset_i && ref_tick_i && !local_pps_i) |=> (state.sub == $past(state.sub) + 24'h000001))
        else $error("subsecond count did not advance on tick");

    // R1 no tick, no change
    a_hold_count: assert property (@(posedge clk_i) disable iff (reset_i) // R1
        (!reset_i && !ref_tick_i && !local_pps_i) |=> $stable(state.sub))
        else $error("subsecond count moved without tick");

    // R2 mark clears output
    a_pps_clear: assert property (@(posedge clk_i) disable iff (reset_i) // R2
        local_pps_i |=> ##1 (ts_p_o.sub_sec == 24'h000000))
        else $error("subsecond field not cleared after second mark");

    // R3 output follows count
    a_sub_output: assert property (@(posedge clk_i) disable iff (reset_i) // R3
        !reset_i |=> (ts_p_o.sub_sec == $past(state.sub)))
        else $error("subsecond output does not follow count");

    // R4 bcd digit range
    a_tod_range: assert property (@(posedge clk_i) disable iff (reset_i) // R4
        (ts_p_o.super_sec.sec_units <= 4'h9) && (ts_p_o.super_sec.min_units <= 4'h9))
        else $error("time of day digit out of range");

    // R5 field placement
    a_tod_pack: assert property (@(posedge clk_i) disable iff (reset_i) // R5
        !reset_i |=> (ts_p_o.super_sec == $past(tod)))
        else $error("supersecond field misplaced");

    // R6 pair halves complementary
    a_diff_pair: assert property (@(posedge clk_i) disable iff (reset_i) // R6
        (ts_n_o == ~ts_p_o))
        else $error("differential pair not complementary");

    // R7 report opens frame
    a_report_start: assert property (@(posedge clk_i) disable iff (reset_i) // R7
        (!reset_i && report && !offset_busy_o) |=> (!offset_tx_o && offset_busy_o) [*2])
        else $error("offset report did not start with a start bit");

    // R8 hour tens carry only leaves 23, so both hour digits return to zero
    a_hour_wrap: assert property (@(posedge clk_i) disable iff (reset_i) // R8
        (!reset_i && c_ht && !set_time_i) |=> (ht == 4'h0 && hu == 4'h0))
        else $error("hours did not wrap from 23");

endmodule

// ---- rtl/timestamp_pkg.sv ----
// Operation
// R1 - advance the subsecond count on every 5 MHz reference tick, 200 ns each
// R2 - clear the subsecond count when the per-second pulse arrives
// R3 - subsecond value is 24-bit binary count of 200 ns ticks since clear
// R4 - keep time of day as 20-bit BCD hhmmss
// R5 - pack BCD from bit 43 down: 2,4,3,4,3,4 bits of hh mm ss
// R6 - drive the 44-bit timestamp out as differential pairs
// R7 - measure local versus satellite second offset and send it over RS-232
// R8 - carry seconds into minutes into hours, hours wrap 23 to 00
package timestamp_pkg;

    // clock and timing figures
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_NS = 200;
    localparam int REF_HZ = 5_000_000;
    localparam int BAUD_HZ = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam logic [10:0] BIT_LAST = 11'(BIT_CYCLES - 1);

    // widths and field positions
    localparam int SUB_W = 24;
    localparam int SUPER_W = 20;
    localparam int TS_W = 44;
    localparam int SUPER_LSB = 24;
    localparam logic [22:0] GAP_MAX = 23'h7fffff;

    // digit wrap values
    localparam logic [3:0] UNITS_LAST = 4'h9;
    localparam logic [3:0] TENS6_LAST = 4'h5;
    localparam logic [3:0] HOUR_TENS_LAST = 4'h2;
    localparam logic [3:0] HOUR_UNITS_AT2_LAST = 4'h3;

    // serial frame
    localparam logic [2:0] DATA_LAST = 3'h7;
    localparam logic [1:0] BYTES_LAST = 2'h2;
    localparam logic LINE_IDLE = 1'b1;

    // reset values
    localparam logic [23:0] SUB_RESET = 24'h000000;

    // time of day, msb first: hour tens down to second units
    typedef struct packed {
        logic [1:0] hour_tens;
        logic [3:0] hour_units;
        logic [2:0] min_tens;
        logic [3:0] min_units;
        logic [2:0] sec_tens;
        logic [3:0] sec_units;
    } time_bcd_t;

    // timestamp word: supersecond above subsecond
    typedef struct packed {
        time_bcd_t super_sec;
        logic [23:0] sub_sec;
    } timestamp_t;

    typedef enum logic [1:0] {MEAS_IDLE, MEAS_LOCAL_FIRST, MEAS_SAT_FIRST} meas_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

endpackage

// ---- rtl/bcd_digit.sv ----
`timescale 1ns/1ps
module bcd_digit (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // control
    input wire logic load_i,
    input wire logic [3:0] load_value_i,
    input wire logic inc_i,
    input wire logic [3:0] last_i,
    // result
    output logic [3:0] digit_o,
    output logic carry_o
);

    typedef struct packed {
        logic [3:0] digit;
    } digit_state_t;

    digit_state_t state;
    digit_state_t next_state;

    // wrap to zero past the last value, carry to the next digit
    always_comb
    begin
        next_state = state;
        if (load_i)
        begin
            next_state.digit = load_value_i;
        end
        else if (inc_i)
        begin
            next_state.digit = carry_o ? 4'h0 : 4'(state.digit + 4'h1);
        end
    end

    assign carry_o = inc_i && (state.digit >= last_i);
    assign digit_o = state.digit;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            state <= '0;
        else
            state <= next_state;
    end

    // R8 digit wraps to zero
    a_digit_wrap: assert property (@(posedge clk_i) disable iff (reset_i) // R8
        (!reset_i && carry_o && !load_i) |=> (digit_o == 4'h0))
        else $error("digit did not wrap after carry");

    // R8 digit steps by one
    a_digit_step: assert property (@(posedge clk_i) disable iff (reset_i) // R8
        (!reset_i && inc_i && !carry_o && !load_i) |=> (digit_o == $past(digit_o) + 4'h1))
        else $error("digit did not advance by one");

endmodule

// ---- test/event_stamp_sink.sv ----
`timescale 1ns/1ps
// far-side event module: takes the stamp from the true halves of its pairs, decodes the offset line
module event_stamp_sink (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // differential stamp and offset line
    input wire timestamp_pkg::timestamp_t ts_p_i,
    input wire timestamp_pkg::timestamp_t ts_n_i,
    input wire logic line_i,
    // decoded results
    output logic [43:0] stamp_o,
    output logic pair_ok_o,
    output logic [7:0] byte_o,
    output logic byte_valid_o,
    output logic frame_ok_o
);
    int cnt;
    int bitn;
    logic busy;
    logic start_ok;

    // pair polarity check
    // a pair only counts when the halves differ on every bit
    assign pair_ok_o = (ts_n_i === ~ts_p_i);
    assign stamp_o = ts_p_i;

    // offset line decode
    // samples mid-bit so a slightly slow or fast sender still decodes
    always @(posedge clk_i)
    begin
        byte_valid_o <= 1'b0;
        if (reset_i)
        begin
            busy <= 1'b0;
            frame_ok_o <= 1'b0;
        end
        else if (!busy)
        begin
            if (line_i === 1'b0)
            begin
                busy <= 1'b1;
                cnt <= timestamp_pkg::BIT_CYCLES / 2;
                bitn <= 0;
            end
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
        else
        begin
            cnt <= timestamp_pkg::BIT_CYCLES - 1;
            bitn <= bitn + 1;
            if (bitn == 0)
                start_ok <= (line_i === 1'b0);
            else if (bitn <= 8)
                byte_o <= {line_i, byte_o[7:1]}; // lsb arrives first
            else
            begin
                busy <= 1'b0;
                byte_valid_o <= 1'b1;
                frame_ok_o <= start_ok && (line_i === 1'b1);
            end
        end
    end
endmodule

// ---- test/event_timestamp_counter_bench.sv ----
`timescale 1ns/1ps
module event_timestamp_counter_bench;
    logic clk_i, reset_i, ref_tick_i, local_pps_i, sat_pps_i, set_time_i;
    timestamp_pkg::time_bcd_t set_value_i;
    timestamp_pkg::timestamp_t ts_p, ts_n;
    logic tx, busy, pair_ok, byte_valid, frame_ok;
    logic [43:0] stamp;
    logic [7:0] rx_byte;
    int err_total, checks, seed, sub_m, h, m, s, sh, sm, ss, k, n;
    logic [43:0] exp_ts;
    logic cmp;
    int q[$];
    int hours[4] = '{23, 9, 19, 0};

    event_timestamp_counter event_timestamp_counter_i (.clk_i(clk_i), .reset_i(reset_i),
        .ref_tick_i(ref_tick_i), .local_pps_i(local_pps_i), .sat_pps_i(sat_pps_i),
        .set_time_i(set_time_i), .set_value_i(set_value_i), .ts_p_o(ts_p), .ts_n_o(ts_n),
        .offset_tx_o(tx), .offset_busy_o(busy));
    event_stamp_sink event_stamp_sink_i (.clk_i(clk_i), .reset_i(reset_i), .ts_p_i(ts_p),
        .ts_n_i(ts_n), .line_i(tx), .stamp_o(stamp), .pair_ok_o(pair_ok), .byte_o(rx_byte),
        .byte_valid_o(byte_valid), .frame_ok_o(frame_ok));

    // 100 ns clock
    always #50 clk_i = ~clk_i;

    // 5 MHz reference: high every second clock
    always @(posedge clk_i) ref_tick_i <= ~ref_tick_i;

    task automatic check(input logic [43:0] got, input logic [43:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches %0d of %0d comparisons", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [19:0] bcd(input int hh, input int mm, input int sc);
        return {2'(hh / 10), 4'(hh % 10), 3'(mm / 10), 4'(mm % 10), 3'(sc / 10), 4'(sc % 10)};
    endfunction

    // one-cycle second marks, held across one sampling edge
    task automatic pulse(input logic loc, input logic sat);
        @(posedge clk_i);
        local_pps_i <= loc;
        sat_pps_i <= sat;
        @(posedge clk_i);
        local_pps_i <= 1'b0;
        sat_pps_i <= 1'b0;
    endtask

    // preset time of day, optionally together with a second mark
    task automatic preset(input int hh, input int mm, input int sc, input logic loc);
        @(posedge clk_i);
        sh = hh;
        sm = mm;
        ss = sc;
        set_value_i <= bcd(hh, mm, sc);
        set_time_i <= 1'b1;
        local_pps_i <= loc;
        @(posedge clk_i);
        set_time_i <= 1'b0;
        local_pps_i <= 1'b0;
    endtask

    // queue the three bytes of a report and wait for the line to finish
    task automatic expect_report(input int v);
        q.push_back((v >> 16) & 255);
        q.push_back((v >> 8) & 255);
        q.push_back(v & 255);
        @(posedge clk_i);
        @(negedge clk_i);
        check({43'h0, busy}, 44'h1, "busy after report");
        check({43'h0, tx}, 44'h0, "start bit");
        for (k = 0; k < 35000 && busy !== 1'b0; k++)
            @(negedge clk_i);
        if (k >= 35000)
        begin
            err_total++;
            $display("unexpected at %0t: report never ended", $time);
            conclude();
        end
        check(44'(q.size()), 44'h0, "bytes missing");
    endtask

    // behavioural model: state after the previous edge is what the outputs show now
    always @(posedge clk_i)
    begin
        exp_ts = {bcd(h, m, s), 24'(sub_m)};
        cmp = !reset_i;
        if (reset_i)
        begin
            sub_m = 0;
            h = 0;
            m = 0;
            s = 0;
        end
        else
        begin
            if (local_pps_i)
                sub_m = 0;
            else if (ref_tick_i)
                sub_m = (sub_m + 1) % (1 << 24);
            if (set_time_i)
            begin
                h = sh;
                m = sm;
                s = ss;
            end
            else if (local_pps_i)
            begin
                s = (s + 1) % 60;
                m = (s == 0) ? (m + 1) % 60 : m;
                h = (s == 0 && m == 0) ? (h + 1) % 24 : h;
            end
        end
    end

    // compare once outputs have settled
    always @(negedge clk_i)
    begin
        if (cmp)
        begin
            check(stamp, exp_ts, "timestamp");
            check({43'h0, pair_ok}, 44'h1, "pair polarity");
        end
        if (byte_valid)
        begin
            check({43'h0, frame_ok}, 44'h1, "framing");
            if (q.size() == 0)
                check({36'h0, rx_byte}, 44'hfff, "extra byte");
            else
                check({36'h0, rx_byte}, 44'(q.pop_front()), "report byte");
        end
    end

    initial
    begin
        {clk_i, ref_tick_i, local_pps_i, sat_pps_i, set_time_i} = 5'h00;
        reset_i = 1'b1;
        set_value_i = 20'h00000;
        {err_total, checks, sub_m, h, m, s, sh, sm, ss} = 0;
        cmp = 1'b0;
        seed = 32'h4877d5c8;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        check(ts_p, 44'h0, "reset stamp");
        check(ts_n, {44{1'b1}}, "reset complement");
        check({42'h0, tx, busy}, 44'h2, "reset line");
        // seconds of random length, marks land on tick and idle cycles alike
        repeat (8)
        begin
            n = 3 + ({$random(seed)} % 40);
            repeat (n) @(posedge clk_i);
            pulse(1'b1, 1'b0);
        end
        // carries at every digit boundary
        foreach (hours[i])
        begin
            preset(hours[i], 59, 58 + (i % 2), 1'b0);
            pulse(1'b1, 1'b0);
            pulse(1'b1, 1'b0);
        end
        // random presets, each together with a mark so the load must win
        repeat (4)
        begin
            preset({$random(seed)} % 24, {$random(seed)} % 60, {$random(seed)} % 60, 1'b1);
            repeat (5) pulse(1'b1, 1'b0);
        end
        // local first, repeated local restarts the count: gap 121
        pulse(1'b1, 1'b0);
        @(posedge clk_i);
        pulse(1'b1, 1'b0);
        repeat (120) @(posedge clk_i);
        pulse(1'b0, 1'b1);
        expect_report(121);
        // satellite first, 300 cycles apart: gap 299 with sign set
        pulse(1'b0, 1'b1);
        repeat (298) @(posedge clk_i);
        pulse(1'b1, 1'b0);
        expect_report(32'h80012b);
        // both marks in one cycle: zero offset
        pulse(1'b1, 1'b1);
        expect_report(0);
        conclude();
    end
endmodule
